// *** rtl/acr_readout_seq.sv ***
// Readout sequencer stepping 64 sampled channels onto two output drivers
//
// Overview of operation
// [RULE1] Driver 1 carries 63..32, driver 0 31..0
// [RULE2] Select high simultaneous, low sequential
// [RULE3] Read start pulse begins read, clears counter
// [RULE4] Sequential: channel 63 on first clock after fall
// [RULE5] Sequential: each driver steps every four clocks
// [RULE6] Sequential: driver 0 lags driver 1 two clocks
// [RULE7] Tristate strap floats idle drivers, else common mode
// [RULE8] Sequential data every second clock, clock max 15 MHz
// [RULE9] Simultaneous: both drivers step every clock
// [RULE10] Simultaneous read takes 33 clocks, max 3.75 MHz
// [RULE11] Controller raises integrator reset with read start
// [RULE12] Controller may stop clock after 133 or 33
// [RULE13] Controller may start read after signal sample
// [RULE14] After read, wait for integrator reset and start
// [RULE15] Controller gives 133 or 33 clocks after reset
// [RULE16] Direction select chooses up or down polarity
// [RULE17] End flag low while read in progress
// [RULE18] Counter frozen after last channel until next start
// [RULE19] End flag rises as drivers leave data state
`timescale 1ns/100ps
module acr_readout_seq (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire acr_pkg::acr_ctl_t      ctlIn,
    input  wire logic                   simultaneousSelect,
    input  wire logic                   tristateEnable,
    input  wire logic                   integrateDirectionSel,
    output acr_pkg::acr_drv_t [1:0]     drvOut,
    output logic                        endOfReadFlag,
    output logic                        integrateDown,
    output logic                        rateError
);

    acr_pkg::acr_ctl_t   ctlPrev_ff;
    acr_pkg::acr_state_t state_ff;
    acr_pkg::acr_state_t nxt_state;
    logic [7:0]          cnt_ff;
    logic [7:0]          nxt_cnt;
    logic                simul_ff;
    logic                irstSeen_ff;
    logic                eor_ff;
    logic                dirDown_ff;
    logic [3:0]          per_ff;
    logic                rateErr_ff;
    logic [1:0]          drvLoad;
    logic [1:0]          drvStep;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on the controller inputs
    wire startRise = ctlIn.readStart & ~ctlPrev_ff.readStart;
    wire startFall = ~ctlIn.readStart & ctlPrev_ff.readStart;
    wire irstRise  = ctlIn.intReset & ~ctlPrev_ff.intReset;
    wire clkRise   = ctlIn.readClk & ~ctlPrev_ff.readClk;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctlPrev_ff <= '0;
        end else begin
            ctlPrev_ff <= ctlIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decodes shared by the state machine and the drivers
    wire inRead    = (state_ff == acr_pkg::ST_READ);
    wire inWait    = (state_ff == acr_pkg::ST_WAIT);
    wire loadEvt   = (state_ff == acr_pkg::ST_PEND) && clkRise;          // [RULE4]
    wire readStep  = inRead && clkRise;
    wire endHit    = simul_ff ? (cnt_ff == acr_pkg::CNT_SIM_END)
                              : (cnt_ff == acr_pkg::CNT_SEQ_END);
    wire lastEdge  = readStep && endHit;
    // Both the integrator reset and a new start must be seen to leave wait
    wire waitDone  = inWait && (irstSeen_ff || irstRise) && startRise;    // [RULE14]
    wire armStart  = startRise && ((state_ff == acr_pkg::ST_ARMED) || waitDone);
    wire seqD0Load = readStep && !simul_ff && (cnt_ff == acr_pkg::CNT_SEQ_DRV0_LOAD);

    ////////////////////////////////////////////////////////////////////////////
    // Read state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            acr_pkg::ST_ARMED: begin
                if (startFall) begin
                    nxt_state = acr_pkg::ST_PEND;                        // [RULE3]
                end
            end
            acr_pkg::ST_PEND: begin
                if (clkRise) begin
                    nxt_state = acr_pkg::ST_READ;                        // [RULE4]
                end
            end
            acr_pkg::ST_READ: begin
                if (lastEdge) begin
                    nxt_state = acr_pkg::ST_WAIT;                        // [RULE14]
                end
            end
            acr_pkg::ST_WAIT: begin
                if (waitDone) begin
                    nxt_state = acr_pkg::ST_ARMED;                       // [RULE14]
                end
            end
            default: begin
                nxt_state = acr_pkg::ST_ARMED;
            end
        endcase
    end

    // Channel counter: cleared by a start, frozen once the read is over
    always_comb begin
        nxt_cnt = cnt_ff;
        if (armStart || loadEvt) begin
            nxt_cnt = 8'h00;                                             // [RULE3]
        end else if (readStep && !endHit) begin
            nxt_cnt = cnt_ff + 8'h01;                                    // [RULE18]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= acr_pkg::ST_ARMED;
            cnt_ff   <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // Mode is latched at the first clock so a pin change mid-read is harmless
    always_ff @(posedge clk) begin
        if (rst) begin
            simul_ff <= 1'b0;
        end else if (loadEvt) begin
            simul_ff <= simultaneousSelect;                              // [RULE2]
        end
    end

    // Integrator reset seen during wait; a start clears it
    always_ff @(posedge clk) begin
        if (rst) begin
            irstSeen_ff <= 1'b0;
        end else if (inWait && irstRise) begin
            irstSeen_ff <= 1'b1;                                         // [RULE14]
        end else if (!inWait) begin
            irstSeen_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // End-of-read flag: low from the start pulse until the last step
    always_ff @(posedge clk) begin
        if (rst) begin
            eor_ff <= 1'b1;
        end else if (armStart) begin
            eor_ff <= 1'b0;                                              // [RULE17]
        end else if (lastEdge) begin
            eor_ff <= 1'b1;                                              // [RULE19]
        end
    end

    // Direction strap sets reset level and output polarity downstream
    always_ff @(posedge clk) begin
        if (rst) begin
            dirDown_ff <= 1'b0;
        end else begin
            dirDown_ff <= integrateDirectionSel;                         // [RULE16]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Readout clock period check; sticky until the first readout clock of the next read
    wire [3:0] minPer  = simul_ff ? acr_pkg::SIM_MIN_PERIOD : acr_pkg::SEQ_MIN_PERIOD;
    // One bit wider so a saturated count cannot wrap to zero
    wire [4:0] perNext = {1'b0, per_ff} + 5'h01;
    wire       tooFast = readStep && (perNext < {1'b0, minPer});

    always_ff @(posedge clk) begin
        if (rst) begin
            per_ff     <= 4'h0;
            rateErr_ff <= 1'b0;
        end else begin
            per_ff     <= clkRise ? 4'h0
                                  : ((per_ff == acr_pkg::PERIOD_SAT) ? per_ff : per_ff + 4'h1);
            if (tooFast) begin
                rateErr_ff <= 1'b1;                                      // [RULE8] [RULE10]
            end else if (loadEvt) begin
                rateErr_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Driver load and step strobes
    assign drvLoad[1] = loadEvt;                                         // [RULE4]
    assign drvLoad[0] = (loadEvt && simultaneousSelect) || seqD0Load;    // [RULE6] [RULE9]
    // In sequential mode alternate drivers so fresh data appears every second clock
    assign drvStep[1] = readStep
                        && (simul_ff || (cnt_ff[1:0] == acr_pkg::SEQ_DRV1_STEP_PH)); // [RULE5]
    assign drvStep[0] = readStep
                        && (simul_ff || (cnt_ff[1:0] == acr_pkg::SEQ_DRV0_STEP_PH)); // [RULE8]

    // Driver 1 takes the upper half, driver 0 the lower
    for (genvar i = 0; i < 2; i++) begin : g_drv
        acr_driver #(
            .TOP_CH ((i == 1) ? acr_pkg::DRV1_TOP_CH : acr_pkg::DRV0_TOP_CH) // [RULE1]
        ) u_drv (
            .clk            (clk),
            .rst            (rst),
            .load           (drvLoad[i]),
            .step           (drvStep[i]),
            .tristateEnable (tristateEnable),
            .drv            (drvOut[i])
        );
    end

    assign endOfReadFlag = eor_ff;
    assign integrateDown = dirDown_ff;
    assign rateError     = rateErr_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks; the rise counter is independent of the channel counter
    logic [7:0] rises_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            rises_ff <= 8'h00;
        end else if (loadEvt) begin
            rises_ff <= 8'h01;
        end else if (readStep) begin
            rises_ff <= rises_ff + 8'h01;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_seqD1Step;
        readStep && !simul_ff && (cnt_ff[1:0] == acr_pkg::SEQ_DRV1_STEP_PH)
        && drvOut[1].dataOn && (drvOut[1].chan != 6'h20);
    endsequence

    sequence s_seqD1Hold;
        readStep && !simul_ff && (cnt_ff[1:0] != acr_pkg::SEQ_DRV1_STEP_PH);
    endsequence

    sequence s_simStep;
        readStep && simul_ff && drvOut[1].dataOn && (drvOut[1].chan != 6'h20);
    endsequence

    AST_FIRST_CH: assert property (loadEvt |=> drvOut[1].dataOn   // [RULE4]
        && drvOut[1].chan == 6'h3f && !endOfReadFlag)
        else $error("first channel not 63 on driver 1");

    AST_HALVES: assert property ((drvOut[1].dataOn -> drvOut[1].chan >= 6'h20)   // [RULE1]
        && (drvOut[0].dataOn -> drvOut[0].chan <= 6'h1f))
        else $error("channel on wrong driver");

    AST_SEQ_STEP: assert property (s_seqD1Step |=>   // [RULE5]
        drvOut[1].chan == $past(drvOut[1].chan) - 6'h01)
        else $error("driver 1 did not step");

    AST_SEQ_HOLD: assert property (s_seqD1Hold |=> $stable(drvOut[1].chan))   // [RULE8]
        else $error("driver 1 stepped off phase");

    AST_SKEW: assert property (loadEvt && !simultaneousSelect   // [RULE6]
        |=> !drvOut[0].dataOn ##1 (!drvOut[0].dataOn || !clkRise)[*1])
        else $error("driver 0 started early");

    AST_D0_START: assert property (seqD0Load |=>   // [RULE6]
        drvOut[0].dataOn && drvOut[0].chan == 6'h1f && cnt_ff == 8'h02)
        else $error("driver 0 not two clocks behind");

    AST_SIM_STEP: assert property (s_simStep |=>   // [RULE9]
        drvOut[0].chan == $past(drvOut[0].chan) - 6'h01
        && drvOut[1].chan == $past(drvOut[1].chan) - 6'h01)
        else $error("simultaneous drivers not stepping together");

    AST_LENGTH: assert property (lastEdge |->   // [RULE10]
        rises_ff == (simul_ff ? acr_pkg::SIM_TOTAL_CLOCKS - 8'h01
                              : acr_pkg::SEQ_TOTAL_CLOCKS - 8'h01))
        else $error("read length wrong");

    AST_END: assert property (lastEdge |=> endOfReadFlag   // [RULE19]
        && !drvOut[0].dataOn && !drvOut[1].dataOn)
        else $error("end flag not aligned with drivers");

    AST_EOR_LOW: assert property (inRead |-> !endOfReadFlag)   // [RULE17]
        else $error("end flag high during read");

    AST_TRISTATE: assert property ($past(tristateEnable) && !drvOut[1].dataOn   // [RULE7]
        |-> !drvOut[1].outEnable && !drvOut[1].cmHold)
        else $error("idle driver not floating");

    AST_WAIT: assert property (inWait && !startRise |=> inWait && $stable(cnt_ff)) // [RULE14]
        else $error("left wait without start");

    AST_START_CLR: assert property (armStart |=> cnt_ff == 8'h00 && !endOfReadFlag) // [RULE3]
        else $error("start did not clear counter");

    AST_DIR: assert property (integrateDown == $past(integrateDirectionSel))   // [RULE16]
        else $error("direction not followed");

endmodule : acr_readout_seq

// *** shared/acr_pkg.sv ***
// Shared constants and types for the channel readout sequencer
package acr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Channel map
    localparam logic [5:0] DRV1_TOP_CH   = 6'h3f;  // Driver 1 starts at channel 63
    localparam logic [5:0] DRV0_TOP_CH   = 6'h1f;  // Driver 0 starts at channel 31
    localparam logic [4:0] STEPS_PER_DRV = 5'h1f;  // 32 channels, 31 decrements

    ////////////////////////////////////////////////////////////////////////////
    // Readout clock counts, zero is the edge that shows the first channel
    localparam logic [7:0] CNT_SEQ_DRV0_LOAD = 8'h01;  // Driver 0 starts two clocks late
    localparam logic [7:0] CNT_SEQ_END       = 8'h81;  // Last step in sequential mode
    localparam logic [7:0] CNT_SIM_END       = 8'h1f;  // Last step in simultaneous mode
    localparam logic [1:0] SEQ_DRV1_STEP_PH  = 2'h3;   // Driver 1 steps every fourth clock
    localparam logic [1:0] SEQ_DRV0_STEP_PH  = 2'h1;   // Driver 0 steps two clocks later
    localparam logic [7:0] SEQ_TOTAL_CLOCKS  = 8'h83;  // 131 clocks, load rise included
    localparam logic [7:0] SIM_TOTAL_CLOCKS  = 8'h21;  // 33 clocks for a full read

    ////////////////////////////////////////////////////////////////////////////
    // Readout clock rate limits
    localparam int SYS_CLK_HZ     = 25_000_000;
    localparam int SEQ_CLK_MAX_HZ = 15_000_000;
    localparam int SIM_CLK_MAX_HZ = 3_750_000;
    localparam logic [3:0] SEQ_MIN_PERIOD =
        4'((SYS_CLK_HZ + SEQ_CLK_MAX_HZ - 1) / SEQ_CLK_MAX_HZ);
    localparam logic [3:0] SIM_MIN_PERIOD =
        4'((SYS_CLK_HZ + SIM_CLK_MAX_HZ - 1) / SIM_CLK_MAX_HZ);
    localparam logic [3:0] PERIOD_SAT     = 4'hf;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {ST_ARMED, ST_PEND, ST_READ, ST_WAIT} acr_state_t;

    typedef struct packed {
        logic       readStart;    // read_start_in
        logic       intReset;     // integrator_reset_in
        logic       readClk;      // readout clock from the timing controller
    } acr_ctl_t;

    typedef struct packed {
        logic [5:0] chan;         // Channel connected to the driver
        logic       dataOn;       // Driver presents channel data
        logic       outEnable;    // Driver is not high impedance
        logic       cmHold;       // Driver holds output common-mode level
    } acr_drv_t;

endpackage : acr_pkg

// *** rtl/acr_driver.sv ***
// One differential output driver: channel pointer and output state
`timescale 1ns/100ps
module acr_driver #(
    parameter logic [5:0] TOP_CH = acr_pkg::DRV1_TOP_CH
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              load,
    input  wire logic              step,
    input  wire logic              tristateEnable,
    output acr_pkg::acr_drv_t      drv
);

    logic [5:0] chan_ff;
    logic [4:0] left_ff;
    logic       on_ff;
    logic       oe_ff;
    logic       cm_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Next state; load wins over a step in the same clock
    wire lastStep  = step && on_ff && (left_ff == 5'h00);
    wire midStep   = step && on_ff && (left_ff != 5'h00);
    wire nxt_on    = load ? 1'b1 : (lastStep ? 1'b0 : on_ff);
    wire [5:0] nxt_chan = load ? TOP_CH : (midStep ? chan_ff - 6'h01 : chan_ff);
    wire [4:0] nxt_left = load ? acr_pkg::STEPS_PER_DRV
                               : (midStep ? left_ff - 5'h01 : left_ff);

    // Pointer and data state
    always_ff @(posedge clk) begin
        if (rst) begin
            chan_ff <= 6'h00;
            left_ff <= 5'h00;
            on_ff   <= 1'b0;
        end else begin
            chan_ff <= nxt_chan;
            left_ff <= nxt_left;
            on_ff   <= nxt_on;
        end
    end

    // Idle driver floats or holds common mode by the strap [RULE7]
    always_ff @(posedge clk) begin
        if (rst) begin
            oe_ff <= 1'b0;
            cm_ff <= 1'b0;
        end else begin
            oe_ff <= nxt_on | ~tristateEnable;   // [RULE7]
            cm_ff <= ~nxt_on & ~tristateEnable;  // [RULE7]
        end
    end

    assign drv = '{chan: chan_ff, dataOn: on_ff, outEnable: oe_ff, cmHold: cm_ff};

endmodule : acr_driver

// *** bench/acr_ctl_model.sv ***
// Timing controller model driving read start, integrator reset and readout clock
`timescale 1ns/100ps
module acr_ctl_model (
    input  wire logic         clk,
    output acr_pkg::acr_ctl_t ctl
);

    ////////////////////////////////////////////////////////////////////////////
    // Idle levels, readout clock stands still outside reads
    initial begin
        ctl = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start pulse, integrator reset rising on the same edge for minimum scan
    task automatic startPulse(input logic withReset);
        @(posedge clk);
        ctl.readStart <= 1'b1;
        ctl.intReset  <= withReset;
        repeat (2) @(posedge clk);
        ctl.readStart <= 1'b0;
        repeat (2) @(posedge clk);
        ctl.intReset  <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : startPulse

    ////////////////////////////////////////////////////////////////////////////
    // One readout clock; half period in system clocks sets the rate
    task automatic readClock(input int half);
        @(posedge clk);
        ctl.readClk <= 1'b1;
        repeat (half) @(posedge clk);
        ctl.readClk <= 1'b0;
        repeat (half - 1) @(posedge clk);
    endtask : readClock

endmodule : acr_ctl_model

// *** bench/acr_readout_seq_tb.sv ***
// Self-checking bench for the channel readout sequencer
`timescale 1ns/100ps
module acr_readout_seq_tb;

    logic                      clk;
    logic                      rst;
    acr_pkg::acr_ctl_t         ctl;
    logic                      simSel;
    logic                      triEn;
    logic                      dirSel;
    acr_pkg::acr_drv_t [1:0]   drvOut;
    logic                      endOfReadFlag;
    logic                      integrateDown;
    logic                      rateError;
    int                        failures;
    int                        n_tests;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, design and controller model
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    acr_readout_seq dut (
        .clk                   (clk),
        .rst                   (rst),
        .ctlIn                 (ctl),
        .simultaneousSelect    (simSel),
        .tristateEnable        (triEn),
        .integrateDirectionSel (dirSel),
        .drvOut                (drvOut),
        .endOfReadFlag         (endOfReadFlag),
        .integrateDown         (integrateDown),
        .rateError             (rateError)
    );

    acr_ctl_model ctlModel (
        .clk (clk),
        .ctl (ctl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Comparison helpers
    task automatic chk1(input logic got, input logic exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %b exp %b", $time, msg, got, exp);
        end
    endtask : chk1

    task automatic chk6(input logic [5:0] got, input logic [5:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %0d exp %0d", $time, msg, got, exp);
        end
    endtask : chk6

    task automatic summarize;
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////
    // Full read in either mode, checked after every readout clock
    task automatic readRun(input logic sim, input logic triSel, input logic integrator_reset_in, input int half);
        int         n;
        int         k;
        int         d;
        logic       bad;
        logic       on [2];
        logic [5:0] ch [2];
        // Too fast a clock only flags; data is then left unjudged
        bad = sim && (2 * half < 7);
        n   = sim ? 33 : 131;
        @(posedge clk);
        simSel <= sim;
        triEn  <= triSel;
        ctlModel.startPulse(integrator_reset_in);
        #1;
        chk1(endOfReadFlag, 1'b0, "end flag not low at start");
        for (k = 0; k < n; k++) begin
            ctlModel.readClock(half);
            #1;
            on[1] = sim ? (k < 32) : (k < 128);
            on[0] = sim ? (k < 32) : (k >= 2 && k < 130);
            ch[1] = sim ? 6'(63 - k) : 6'(63 - k / 4);
            ch[0] = sim ? 6'(31 - k) : 6'(31 - (k - 2) / 4);
            for (d = 0; d < 2 && !bad; d++) begin
                chk1(drvOut[d].dataOn, on[d], "data state");
                if (on[d]) begin
                    chk6(drvOut[d].chan, ch[d], "channel");
                end
                chk1(drvOut[d].outEnable, on[d] | ~triSel, "output enable");
                chk1(drvOut[d].cmHold, ~on[d] & ~triSel, "common mode hold");
            end
            if (!bad) begin
                chk1(endOfReadFlag, k >= n - 1, "end flag timing");
            end
        end
        // Extra clocks after the end must not restart stepping
        for (k = 0; k < 4; k++) begin
            ctlModel.readClock(half);
        end
        #1;
        chk1(drvOut[1].dataOn | drvOut[0].dataOn, 1'b0, "stepping after end");
        chk1(endOfReadFlag, 1'b1, "end flag after read");
        chk1(rateError, bad, "rate flag");
    endtask : readRun

    ////////////////////////////////////////////////////////////////////////////
    // Start without integrator reset is ignored in the wait state
    task automatic waitIgnore;
        ctlModel.startPulse(1'b0);
        #1;
        chk1(endOfReadFlag, 1'b1, "start accepted in wait");
    endtask : waitIgnore

    task automatic directionTest;
        @(posedge clk);
        dirSel <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk1(integrateDown, 1'b1, "integrate down");
        @(posedge clk);
        dirSel <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk1(integrateDown, 1'b0, "integrate up");
    endtask : directionTest

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        failures = 0;
        n_tests  = 0;
        rst      = 1'b1;
        simSel   = 1'b0;
        triEn    = 1'b1;
        dirSel   = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk1(endOfReadFlag, 1'b1, "end flag after reset");
        chk1(drvOut[1].dataOn, 1'b0, "driver idle after reset");
        readRun(1'b0, 1'b1, 1'b0, 2);
        waitIgnore();
        readRun(1'b1, 1'b0, 1'b1, 4);
        readRun(1'b0, 1'b0, 1'b1, 2);
        readRun(1'b1, 1'b1, 1'b1, 2);
        directionTest();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize();
    end

endmodule : acr_readout_seq_tb
